// [ocb_output_bank.sv]
// output configuration object bank with switched output logic and analog scaling
`timescale 1ns/1ns
`include "ocb_defines.svh"
module ocb_output_bank (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire ocb_pkg::ocb_obj_req_t obj_req_i,
  output ocb_pkg::ocb_obj_rsp_t obj_rsp_o,
  input wire logic fault_i,
  input wire logic [1:0] sw_net_sel_i,
  input wire logic [1:0] sw_write_state_i,
  input wire logic [1:0] sw_local_state_i,
  output logic [1:0] sw_drive_o,
  input wire logic [1:0] ao_net_sel_i,
  input wire logic [1:0][15:0] ao_local_value_i,
  output logic [1:0][15:0] ao_field_o,
  output logic [1:0][15:0] ao_kind_o,
  output logic [1:0][7:0] ao_digits_o
);

  ocb_pkg::ocb_bank_t b_r;
  ocb_pkg::ocb_bank_t b_nxt;
  logic scale_start;
  logic scale_done;
  logic [15:0] scale_result;
  logic [15:0] scale_x;
  logic i;
  logic sub_ok;
  logic [1:0] logic_state;

  // 8-bit objects refuse anything in the upper byte
  function automatic logic fits8(input logic [15:0] v);
    fits8 = (v[15:8] == 8'h00);
  endfunction : fits8

  // ****************************************************************
  // analog scheduling
  // ****************************************************************
  // both channels share one divider; an interpolated refresh takes about 37 cycles, a clamped one 2
  assign scale_start = !b_r.busy;
  // source value, points and levels all share the digits of the channel,
  // so the ratio needs no rescaling
  assign scale_x = ao_net_sel_i[b_r.ch] ? b_r.command[b_r.ch]
    : ao_local_value_i[b_r.ch];

  ocb_scaler u_scaler (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .start_i(scale_start),
    .x_i(scale_x),
    .lo_pt_i(b_r.lo_pt[b_r.ch]),
    .hi_pt_i(b_r.hi_pt[b_r.ch]),
    .lo_lvl_i(b_r.lo_lvl[b_r.ch]),
    .hi_lvl_i(b_r.hi_lvl[b_r.ch]),
    .done_o(scale_done),
    .result_o(scale_result)
  );

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    b_nxt = b_r;
    b_nxt.ack = 1'b0;
    b_nxt.abort = 1'b0;
    i = obj_req_i.sub[1];
    sub_ok = (obj_req_i.sub == 8'h01) || (obj_req_i.sub == 8'h02);
    if (scale_start) begin
      b_nxt.busy = 1'b1;
    end
    if (scale_done) begin
      b_nxt.field[b_r.ch] = scale_result;
      b_nxt.ch = !b_r.ch;
      b_nxt.busy = 1'b0;
    end
    for (int k = 0; k < 2; k++) begin
      logic_state[k] = sw_net_sel_i[k] ? sw_write_state_i[k] : sw_local_state_i[k];
      if (fault_i && (b_r.fmode[k] == `OCB_FMODE_APPLY)) begin
        logic_state[k] = b_r.fstate[k];
      end
      // any polarity other than normal inverts the drive
      b_nxt.drive[k] = logic_state[k] ^ (b_r.polarity[k] != `OCB_POLARITY_NORMAL);
    end
    if (obj_req_i.valid) begin
      b_nxt.ack = 1'b1;
      b_nxt.rdata = 16'h0000;
      if (obj_req_i.sub == 8'h00) begin
        b_nxt.abort = obj_req_i.write;
        b_nxt.rdata = obj_req_i.write ? 16'h0000 : {8'h00, `OCB_MAX_SUB};
        unique case (obj_req_i.index)
          `OCB_IDX_POLARITY, `OCB_IDX_FAULT_MODE, `OCB_IDX_FAULT_STATE,
          `OCB_IDX_DIGITS, `OCB_IDX_KIND, `OCB_IDX_COMMAND, `OCB_IDX_LOWER_POINT,
          `OCB_IDX_LOWER_LEVEL, `OCB_IDX_UPPER_POINT, `OCB_IDX_UPPER_LEVEL,
          `OCB_IDX_FIELD: begin
          end
          default: begin
            b_nxt.abort = 1'b1;
            b_nxt.rdata = 16'h0000;
          end
        endcase
      end else if (!sub_ok) begin
        b_nxt.abort = 1'b1;
      end else begin
        unique case (obj_req_i.index)
          `OCB_IDX_POLARITY: begin
            b_nxt.rdata = {8'h00, b_r.polarity[i]};
            if (obj_req_i.write) begin
              if (fits8(obj_req_i.wdata)) begin
                b_nxt.polarity[i] = obj_req_i.wdata[7:0];
              end else begin
                b_nxt.abort = 1'b1;
              end
            end
          end
          `OCB_IDX_FAULT_MODE: begin
            b_nxt.rdata = {8'h00, b_r.fmode[i]};
            if (obj_req_i.write) begin
              if (fits8(obj_req_i.wdata)) begin
                b_nxt.fmode[i] = obj_req_i.wdata[7:0];
              end else begin
                b_nxt.abort = 1'b1;
              end
            end
          end
          `OCB_IDX_FAULT_STATE: begin
            b_nxt.rdata = {15'h0000, b_r.fstate[i]};
            if (obj_req_i.write) begin
              if (obj_req_i.wdata[15:1] == 15'h0000) begin
                b_nxt.fstate[i] = obj_req_i.wdata[0];
              end else begin
                b_nxt.abort = 1'b1;
              end
            end
          end
          `OCB_IDX_DIGITS: begin
            b_nxt.rdata = {8'h00, b_r.digits[i]};
            if (obj_req_i.write) begin
              if (obj_req_i.wdata <= {8'h00, `OCB_DIGITS_MAX}) begin
                b_nxt.digits[i] = obj_req_i.wdata[7:0];
              end else begin
                b_nxt.abort = 1'b1;
              end
            end
          end
          `OCB_IDX_KIND: begin
            b_nxt.rdata = b_r.kind[i];
            if (obj_req_i.write) begin
              b_nxt.kind[i] = obj_req_i.wdata;
            end
          end
          `OCB_IDX_COMMAND: begin
            b_nxt.rdata = b_r.command[i];
            if (obj_req_i.write) begin
              b_nxt.command[i] = obj_req_i.wdata;
            end
          end
          `OCB_IDX_LOWER_POINT: begin
            b_nxt.rdata = b_r.lo_pt[i];
            if (obj_req_i.write) begin
              b_nxt.lo_pt[i] = obj_req_i.wdata;
            end
          end
          `OCB_IDX_LOWER_LEVEL: begin
            b_nxt.rdata = b_r.lo_lvl[i];
            if (obj_req_i.write) begin
              b_nxt.lo_lvl[i] = obj_req_i.wdata;
            end
          end
          `OCB_IDX_UPPER_POINT: begin
            b_nxt.rdata = b_r.hi_pt[i];
            if (obj_req_i.write) begin
              b_nxt.hi_pt[i] = obj_req_i.wdata;
            end
          end
          `OCB_IDX_UPPER_LEVEL: begin
            b_nxt.rdata = b_r.hi_lvl[i];
            if (obj_req_i.write) begin
              b_nxt.hi_lvl[i] = obj_req_i.wdata;
            end
          end
          `OCB_IDX_FIELD: begin
            b_nxt.rdata = b_r.field[i];
            b_nxt.abort = obj_req_i.write;
          end
          default: begin
            b_nxt.abort = 1'b1;
          end
        endcase
        if (b_nxt.abort) begin
          b_nxt.rdata = 16'h0000;
        end
      end
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      b_r <= '0;
      b_r.polarity <= {`OCB_RST_POLARITY, `OCB_RST_POLARITY};
      b_r.fmode <= {`OCB_RST_FAULT_MODE, `OCB_RST_FAULT_MODE};
      b_r.fstate <= {`OCB_RST_FAULT_STATE, `OCB_RST_FAULT_STATE};
      b_r.command <= {`OCB_RST_COMMAND, `OCB_RST_COMMAND};
      b_r.digits <= {`OCB_RST_DIGITS, `OCB_RST_DIGITS};
      b_r.kind <= {`OCB_RST_KIND, `OCB_RST_KIND};
      b_r.lo_pt <= {`OCB_RST_LOWER_POINT_2, `OCB_RST_LOWER_POINT_1};
      b_r.hi_pt <= {`OCB_RST_UPPER_POINT_2, `OCB_RST_UPPER_POINT_1};
      b_r.lo_lvl <= {`OCB_RST_LOWER_LEVEL_2, `OCB_RST_LOWER_LEVEL_1};
      b_r.hi_lvl <= {`OCB_RST_UPPER_LEVEL_2, `OCB_RST_UPPER_LEVEL_1};
      b_r.drive <= 2'h0;
    end else begin
      b_r <= b_nxt;
    end
  end

  assign obj_rsp_o.ack = b_r.ack;
  assign obj_rsp_o.abort = b_r.abort;
  assign obj_rsp_o.rdata = b_r.rdata;
  assign sw_drive_o = b_r.drive;
  assign ao_field_o = b_r.field;
  assign ao_kind_o = b_r.kind;
  assign ao_digits_o = b_r.digits;

endmodule : ocb_output_bank

// [ocb_defines.svh]
// offsets, field values, reset values and limits of the output configuration object bank
`ifndef OCB_DEFINES_SVH
`define OCB_DEFINES_SVH

// ****************************************************************
// object indices
// ****************************************************************
`define OCB_IDX_POLARITY 16'h6240
`define OCB_IDX_FAULT_MODE 16'h6250
`define OCB_IDX_FAULT_STATE 16'h6260
`define OCB_IDX_DIGITS 16'h6302
`define OCB_IDX_KIND 16'h6310
`define OCB_IDX_COMMAND 16'h7300
`define OCB_IDX_LOWER_POINT 16'h7320
`define OCB_IDX_LOWER_LEVEL 16'h7321
`define OCB_IDX_UPPER_POINT 16'h7322
`define OCB_IDX_UPPER_LEVEL 16'h7323
`define OCB_IDX_FIELD 16'h7330

// ****************************************************************
// entries, field values and limits
// ****************************************************************
`define OCB_MAX_SUB 8'h02
`define OCB_DIGITS_MAX 8'h04
`define OCB_FMODE_APPLY 8'h01
`define OCB_POLARITY_NORMAL 8'h00

// ****************************************************************
// reset values and divider step count
// ****************************************************************
`define OCB_RST_POLARITY 8'h00
`define OCB_RST_FAULT_MODE 8'h01
`define OCB_RST_FAULT_STATE 1'h1
`define OCB_RST_DIGITS 8'h03
`define OCB_RST_KIND 16'h0014
`define OCB_RST_COMMAND 16'h0000
`define OCB_RST_LOWER_POINT_1 16'h0A5A
`define OCB_RST_LOWER_POINT_2 16'h01F4
`define OCB_RST_UPPER_POINT_1 16'h1194
`define OCB_RST_UPPER_POINT_2 16'h092E
`define OCB_RST_LOWER_LEVEL_1 16'h012C
`define OCB_RST_LOWER_LEVEL_2 16'h05DC
`define OCB_RST_UPPER_LEVEL_1 16'h05DC
`define OCB_RST_UPPER_LEVEL_2 16'h012C
`define OCB_DIV_STEPS 6'h22

`endif

// [ocb_pkg.sv]
// types of the output configuration object bank
package ocb_pkg;

  // ****************************************************************
  // object access carriers
  // ****************************************************************
  typedef struct packed {
    logic valid;
    logic write;
    logic [15:0] index;
    logic [7:0] sub;
    logic [15:0] wdata;
  } ocb_obj_req_t;

  typedef struct packed {
    logic ack;
    logic abort;
    logic [15:0] rdata;
  } ocb_obj_rsp_t;

  // ****************************************************************
  // bank state
  // ****************************************************************
  typedef struct packed {
    logic [1:0][7:0] polarity;
    logic [1:0][7:0] fmode;
    logic [1:0] fstate;
    logic [1:0][15:0] command;
    logic [1:0][7:0] digits;
    logic [1:0][15:0] kind;
    logic [1:0][15:0] lo_pt;
    logic [1:0][15:0] hi_pt;
    logic [1:0][15:0] lo_lvl;
    logic [1:0][15:0] hi_lvl;
    logic [1:0][15:0] field;
    logic [1:0] drive;
    logic ack;
    logic abort;
    logic [15:0] rdata;
    logic ch;
    logic busy;
  } ocb_bank_t;

  // ****************************************************************
  // scaler state
  // ****************************************************************
  typedef enum logic [1:0] {
    OCB_DIV_IDLE = 2'b00,
    OCB_DIV_RUN = 2'b01,
    OCB_DIV_DONE = 2'b10
  } ocb_div_state_t;

  typedef struct packed {
    ocb_div_state_t state;
    logic [5:0] cnt;
    logic [33:0] quo;
    logic [17:0] rem;
    logic [16:0] den;
    logic neg;
    logic [15:0] base;
    logic [15:0] result;
    logic done;
  } ocb_div_t;

endpackage : ocb_pkg

// [ocb_scaler.sv]
// field level scaler: clamps at the points and interpolates between them
`timescale 1ns/1ns
`include "ocb_defines.svh"
module ocb_scaler (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic start_i,
  input wire logic [15:0] x_i,
  input wire logic [15:0] lo_pt_i,
  input wire logic [15:0] hi_pt_i,
  input wire logic [15:0] lo_lvl_i,
  input wire logic [15:0] hi_lvl_i,
  output logic done_o,
  output logic [15:0] result_o
);

  ocb_pkg::ocb_div_t s_r;
  ocb_pkg::ocb_div_t s_nxt;
  logic [16:0] dx;
  logic [16:0] dy;
  logic [16:0] dy_mag;
  logic [17:0] rem_sh;
  logic [17:0] sum;

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    dx = 17'({x_i[15], x_i} - {lo_pt_i[15], lo_pt_i});
    dy = 17'({hi_lvl_i[15], hi_lvl_i} - {lo_lvl_i[15], lo_lvl_i});
    dy_mag = dy[16] ? 17'(-dy) : dy;
    rem_sh = {s_r.rem[16:0], s_r.quo[33]};
    sum = {s_r.base[15], s_r.base[15], s_r.base} + (s_r.neg ? -{1'b0, s_r.quo[16:0]}
      : {1'b0, s_r.quo[16:0]});
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    unique case (s_r.state)
      ocb_pkg::OCB_DIV_IDLE: begin
        if (start_i) begin
          if ($signed(x_i) <= $signed(lo_pt_i)) begin
            s_nxt.result = lo_lvl_i;
            s_nxt.done = 1'b1;
          end else if ($signed(x_i) >= $signed(hi_pt_i)) begin
            s_nxt.result = hi_lvl_i;
            s_nxt.done = 1'b1;
          end else begin
            // strictly inside, so den is positive and dx below den
            // both factors widened first so the full 34-bit product survives
            s_nxt.quo = {17'h00000, dx} * {17'h00000, dy_mag};
            s_nxt.den = 17'({hi_pt_i[15], hi_pt_i} - {lo_pt_i[15], lo_pt_i});
            s_nxt.neg = dy[16];
            s_nxt.base = lo_lvl_i;
            s_nxt.rem = 18'h00000;
            s_nxt.cnt = `OCB_DIV_STEPS;
            s_nxt.state = ocb_pkg::OCB_DIV_RUN;
          end
        end
      end
      ocb_pkg::OCB_DIV_RUN: begin
        // one quotient bit a cycle keeps the divider small
        s_nxt.quo = {s_r.quo[32:0], 1'b0};
        s_nxt.rem = rem_sh;
        if (rem_sh >= {1'b0, s_r.den}) begin
          s_nxt.rem = rem_sh - {1'b0, s_r.den};
          s_nxt.quo[0] = 1'b1;
        end
        s_nxt.cnt = s_r.cnt - 6'h01;
        if (s_r.cnt == 6'h01) begin
          s_nxt.state = ocb_pkg::OCB_DIV_DONE;
        end
      end
      ocb_pkg::OCB_DIV_DONE: begin
        s_nxt.result = sum[15:0];
        s_nxt.done = 1'b1;
        s_nxt.state = ocb_pkg::OCB_DIV_IDLE;
      end
      default: begin
        s_nxt.state = ocb_pkg::OCB_DIV_IDLE;
      end
    endcase
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign done_o = s_r.done;
  assign result_o = s_r.result;

endmodule : ocb_scaler

// [ocb_net_master.sv]
// network master model issuing object requests to the output bank
`timescale 1ns/1ns
module ocb_net_master (
  input wire logic clk_i,
  output ocb_pkg::ocb_obj_req_t obj_req_o,
  input wire ocb_pkg::ocb_obj_rsp_t obj_rsp_i
);
  initial obj_req_o = '0;
  // ********************************
  // one request, answer read at the edge after the taking edge
  // ********************************
  // lower points are never written, so each stays below its upper point
  task access(input logic wr, input logic [15:0] ix, input logic [7:0] sb,
    input logic [15:0] wd, output logic ack, output logic abt, output logic [15:0] rd);
    @(posedge clk_i);
    obj_req_o <= '{valid: 1'b1, write: wr, index: ix, sub: sb, wdata: wd};
    @(posedge clk_i);
    // released lines show the inverse so a stale request never looks valid
    obj_req_o <= '{valid: 1'b0, write: ~wr, index: ~ix, sub: ~sb, wdata: ~wd};
    @(posedge clk_i);
    ack = obj_rsp_i.ack;
    abt = obj_rsp_i.abort;
    rd = obj_rsp_i.rdata;
  endtask : access
endmodule : ocb_net_master

// [ocb_bank_assertions.sv]
// concurrent checks on the object port of the output bank
`timescale 1ns/1ns
module ocb_bank_chk (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire ocb_pkg::ocb_obj_req_t obj_req_i,
  input wire ocb_pkg::ocb_obj_rsp_t obj_rsp_o
);
  // ********************************
  // object port checks
  // ********************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  chk_ack_latency: assert property (obj_req_i.valid |=> obj_rsp_o.ack)
    else $error("ack missing after request");
  chk_no_stray_ack: assert property (
    !obj_req_i.valid |=> !obj_rsp_o.ack && !obj_rsp_o.abort)
    else $error("ack without request");
  chk_sub0_read: assert property (
    obj_req_i.valid && !obj_req_i.write && obj_req_i.sub == 8'h00
    && obj_req_i.index == 16'h6240 |=> !obj_rsp_o.abort && obj_rsp_o.rdata == 16'h0002)
    else $error("entry count read wrong");
  chk_sub0_write: assert property (
    obj_req_i.valid && obj_req_i.write && obj_req_i.sub == 8'h00
    |=> obj_rsp_o.abort && obj_rsp_o.rdata == 16'h0000)
    else $error("entry count write not refused");
  chk_sub_range: assert property (
    obj_req_i.valid && obj_req_i.sub > 8'h02 |=> obj_rsp_o.abort)
    else $error("entry above two not refused");
  chk_digits_range: assert property (
    obj_req_i.valid && obj_req_i.write
    && obj_req_i.index == 16'h6302 && obj_req_i.wdata > 16'h0004 |=> obj_rsp_o.abort)
    else $error("digits above four accepted");
  chk_state_range: assert property (
    obj_req_i.valid && obj_req_i.write
    && obj_req_i.index == 16'h6260 && obj_req_i.wdata > 16'h0001 |=> obj_rsp_o.abort)
    else $error("fault state above one accepted");
  chk_byte_range: assert property (
    obj_req_i.valid && obj_req_i.write
    && obj_req_i.index == 16'h6240 && obj_req_i.wdata[15:8] != 8'h00 |=> obj_rsp_o.abort)
    else $error("wide polarity accepted");
endmodule : ocb_bank_chk

bind ocb_output_bank ocb_bank_chk ocb_bank_chk_inst (
  .clk_i(clk_i), .reset_i(reset_i), .obj_req_i(obj_req_i), .obj_rsp_o(obj_rsp_o)
);

// [ocb_testbench.sv]
// self-checking testbench of the output configuration object bank
`timescale 1ns/1ns
module testbench;
  logic clk_i, reset_i, fault_i, ack, abt;
  logic [1:0] sw_net_sel_i, sw_write_state_i, sw_local_state_i, sw_drive_o, ao_net_sel_i;
  logic [1:0][15:0] ao_local_value_i, ao_field_o, ao_kind_o;
  logic [1:0][7:0] ao_digits_o;
  logic [15:0] rd, prev;
  ocb_pkg::ocb_obj_req_t obj_req;
  ocb_pkg::ocb_obj_rsp_t obj_rsp;
  int err_count = 0;
  int checks = 0;
  logic [15:0] idx [9] = '{16'h6240, 16'h6250, 16'h6260, 16'h6302, 16'h6310, 16'h7320,
    16'h7321, 16'h7322, 16'h7323};
  logic [15:0] rst1 [9] = '{16'h0000, 16'h0001, 16'h0001, 16'h0003, 16'h0014, 16'h0A5A,
    16'h012C, 16'h1194, 16'h05DC};
  logic [15:0] rst2 [9] = '{16'h0000, 16'h0001, 16'h0001, 16'h0003, 16'h0014, 16'h01F4,
    16'h05DC, 16'h092E, 16'h012C};
  logic [15:0] pv [3] = '{16'h0A5A, 16'h0DF7, 16'h1388};
  logic [15:0] fl [3] = '{16'h012C, 16'h0384, 16'h05DC};

  ocb_output_bank ocb_output_bank_inst (.clk_i(clk_i), .reset_i(reset_i), .obj_req_i(obj_req),
    .obj_rsp_o(obj_rsp), .fault_i(fault_i), .sw_net_sel_i(sw_net_sel_i),
    .sw_write_state_i(sw_write_state_i), .sw_local_state_i(sw_local_state_i),
    .sw_drive_o(sw_drive_o), .ao_net_sel_i(ao_net_sel_i), .ao_local_value_i(ao_local_value_i),
    .ao_field_o(ao_field_o), .ao_kind_o(ao_kind_o), .ao_digits_o(ao_digits_o));
  ocb_net_master ocb_net_master_inst (.clk_i(clk_i), .obj_req_o(obj_req), .obj_rsp_i(obj_rsp));

  // ********************************
  // tasks
  // ********************************
  task cmp(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  task obj(input logic wr, input logic [15:0] ix, input logic [7:0] sb, input logic [15:0] wd,
    input logic ea, input logic [15:0] er);
    ocb_net_master_inst.access(wr, ix, sb, wd, ack, abt, rd);
    cmp({15'h0000, ack}, 16'h0001);
    cmp({15'h0000, abt}, {15'h0000, ea});
    cmp(rd, er);
  endtask : obj

  // drive is registered from inputs taken one edge earlier, so allow three edges
  task drv(input logic [1:0] e);
    repeat (3) @(posedge clk_i);
    cmp({14'h0000, sw_drive_o}, {14'h0000, e});
  endtask : drv

  task end_sim;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_sim

  // ********************************
  // clock, reset and tests
  // ********************************
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    end_sim();
  end

  initial begin
    reset_i = 1'b1;
    fault_i = 1'b0;
    sw_net_sel_i = 2'b00;
    sw_write_state_i = 2'b00;
    sw_local_state_i = 2'b00;
    ao_net_sel_i = 2'b00;
    ao_local_value_i = '0;
    repeat (16) @(posedge clk_i);
    reset_i <= 1'b0;
    for (int i = 0; i < 9; i++) begin
      obj(1'b0, idx[i], 8'h00, 16'h0000, 1'b0, 16'h0002);
      obj(1'b0, idx[i], 8'h01, 16'h0000, 1'b0, rst1[i]);
      obj(1'b0, idx[i], 8'h02, 16'h0000, 1'b0, rst2[i]);
    end
    cmp(ao_kind_o[0], 16'h0014);
    $display("test reset values done");
    obj(1'b1, 16'h6240, 8'h00, 16'h0001, 1'b1, 16'h0000);
    obj(1'b0, 16'h6250, 8'h03, 16'h0000, 1'b1, 16'h0000);
    obj(1'b0, 16'h1234, 8'h01, 16'h0000, 1'b1, 16'h0000);
    obj(1'b1, 16'h6240, 8'h01, 16'h0100, 1'b1, 16'h0000);
    obj(1'b1, 16'h6260, 8'h01, 16'h0002, 1'b1, 16'h0000);
    obj(1'b1, 16'h6302, 8'h01, 16'h0005, 1'b1, 16'h0000);
    obj(1'b1, 16'h6302, 8'h01, 16'h0004, 1'b0, 16'h0003);
    obj(1'b0, 16'h6302, 8'h01, 16'h0000, 1'b0, 16'h0004);
    obj(1'b1, 16'h6310, 8'h02, 16'h0015, 1'b0, 16'h0014);
    obj(1'b1, 16'h7330, 8'h01, 16'h0000, 1'b1, 16'h0000);
    repeat (2) @(posedge clk_i);
    cmp({8'h00, ao_digits_o[0]}, 16'h0004);
    cmp({8'h00, ao_digits_o[1]}, 16'h0003);
    cmp(ao_kind_o[1], 16'h0015);
    $display("test refusals done");
    sw_local_state_i <= 2'b01;
    drv(2'b01);
    fault_i <= 1'b1;
    drv(2'b11);
    obj(1'b1, 16'h6250, 8'h02, 16'h0000, 1'b0, 16'h0001);
    drv(2'b01);
    obj(1'b1, 16'h6260, 8'h01, 16'h0000, 1'b0, 16'h0001);
    drv(2'b00);
    fault_i <= 1'b0;
    sw_net_sel_i <= 2'b11;
    sw_write_state_i <= 2'b10;
    drv(2'b10);
    obj(1'b1, 16'h6240, 8'h01, 16'h0080, 1'b0, 16'h0000);
    drv(2'b11);
    $display("test switched outputs done");
    // digits stay at four here: scaling must not depend on them
    ao_net_sel_i <= 2'b01;
    ao_local_value_i[1] <= 16'h0064;
    prev = 16'h0000;
    for (int i = 0; i < 3; i++) begin
      obj(1'b1, 16'h7300, 8'h01, pv[i], 1'b0, prev);
      prev = pv[i];
      repeat (80) @(posedge clk_i);
      cmp(ao_field_o[0], fl[i]);
      obj(1'b0, 16'h7330, 8'h01, 16'h0000, 1'b0, fl[i]);
    end
    cmp(ao_field_o[1], 16'h05DC);
    // upper level below the lower one gives a falling response
    obj(1'b1, 16'h7323, 8'h01, 16'h0064, 1'b0, 16'h05DC);
    obj(1'b1, 16'h7300, 8'h01, 16'h0DF7, 1'b0, 16'h1388);
    repeat (80) @(posedge clk_i);
    cmp(ao_field_o[0], 16'h00C8);
    obj(1'b1, 16'h7300, 8'h01, 16'h1388, 1'b0, 16'h0DF7);
    repeat (80) @(posedge clk_i);
    cmp(ao_field_o[0], 16'h0064);
    $display("test analog scaling done");
    end_sim();
  end
endmodule : testbench
